// >>> hw/fcp_pkg.sv
// Constants, types and decoders for the flash code protection block
package fcp_pkg;
    localparam int FLASH_AW   = 14;
    localparam int EE_AW      = 8;
    localparam int ID_AW      = 3;
    localparam int NREG       = 5;
    localparam int PROT_W     = 3 * NREG + 3;
    localparam int BLK_LK_MSB = 3;
    localparam int BIT_EE_ACC = 7;
    localparam int BIT_EE_WR  = 7;
    localparam int BIT_BOOT_LK = 6;
    localparam int BIT_CFG_WR = 5;
    localparam int BIT_DEBUG  = 7;

    localparam logic [21:0] FLASH_BASE = 22'h000000;
    localparam logic [21:0] BOOT_LAST  = 22'h0001ff;
    localparam logic [21:0] BLK0_BASE  = 22'h000200;
    localparam logic [21:0] BLK0_LAST  = 22'h000fff;
    localparam logic [21:0] BLK1_BASE  = 22'h001000;
    localparam logic [21:0] BLK1_LAST  = 22'h001fff;
    localparam logic [21:0] BLK2_BASE  = 22'h002000;
    localparam logic [21:0] BLK2_LAST  = 22'h002fff;
    localparam logic [21:0] BLK3_BASE  = 22'h003000;
    localparam logic [21:0] FLASH_LAST = 22'h003fff;
    localparam logic [21:0] ID_BASE    = 22'h200000;
    localparam logic [21:0] ID_LAST    = 22'h200007;
    localparam logic [21:0] CFG_DEBUG  = 22'h300006;
    localparam logic [21:0] CFG_EXT_LO = 22'h300008;
    localparam logic [21:0] CFG_EXT_HI = 22'h300009;
    localparam logic [21:0] CFG_WR_LO  = 22'h30000a;
    localparam logic [21:0] CFG_WR_HI  = 22'h30000b;
    localparam logic [21:0] CFG_RD_LO  = 22'h30000c;
    localparam logic [21:0] CFG_RD_HI  = 22'h30000d;
    localparam logic [21:0] DEVID_LO   = 22'h3ffffe;
    localparam logic [21:0] DEVID_HI   = 22'h3fffff;

    localparam logic [2:0] RGN_BOOT = 3'h0;
    localparam logic [2:0] RGN_BLK0 = 3'h1;
    localparam logic [2:0] RGN_BLK1 = 3'h2;
    localparam logic [2:0] RGN_BLK2 = 3'h3;
    localparam logic [2:0] RGN_BLK3 = 3'h4;
    localparam logic [2:0] RGN_NONE = 3'h7;

    localparam logic [7:0]          BYTE_ERASED  = 8'hff;
    localparam logic [7:0]          BYTE_ZERO    = 8'h00;
    localparam logic [NREG-1:0]     LOCKS_ERASED = 5'h1f;
    localparam logic [FLASH_AW-1:0] EE_SWEEP_END = 14'h0100;

    typedef enum logic [1:0] {
        OP_READ        = 2'b00,
        OP_WRITE       = 2'b01,
        OP_CHIP_ERASE  = 2'b10,
        OP_BLOCK_ERASE = 2'b11
    } fcp_op_t;

    typedef enum logic {
        ST_IDLE  = 1'b0,
        ST_ERASE = 1'b1
    } fcp_state_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        ee;
        logic [21:0] addr;
        logic [21:0] pc;
        logic [7:0]  wdata;
    } fcp_cpu_req_t;

    typedef struct packed {
        logic        valid;
        fcp_op_t     op;
        logic        ee;
        logic [21:0] addr;
        logic [7:0]  wdata;
    } fcp_pgm_req_t;

    typedef struct packed {
        logic       done;
        logic [7:0] rdata;
    } fcp_resp_t;

    typedef struct packed {
        logic [NREG-1:0] ext;
        logic [NREG-1:0] wr;
        logic [NREG-1:0] rd;
        logic            ee_acc;
        logic            ee_wr;
        logic            cfg_wr;
        logic [7:0]      debug;
    } fcp_locks_t;

    localparam fcp_locks_t LOCKS_RESET = '{ext: LOCKS_ERASED, wr: LOCKS_ERASED, rd: LOCKS_ERASED,
                                           ee_acc: 1'b1, ee_wr: 1'b1, cfg_wr: 1'b1, debug: BYTE_ERASED};

    function automatic logic [2:0] region_of(input logic [21:0] a);
        if (a <= BOOT_LAST) return RGN_BOOT;
        else if (a <= BLK0_LAST) return RGN_BLK0;
        else if (a <= BLK1_LAST) return RGN_BLK1;
        else if (a <= BLK2_LAST) return RGN_BLK2;
        else if (a <= FLASH_LAST) return RGN_BLK3;
        else return RGN_NONE;
    endfunction

    function automatic logic [FLASH_AW-1:0] region_base(input logic [2:0] r);
        case (r)
            RGN_BLK0: return BLK0_BASE[FLASH_AW-1:0];
            RGN_BLK1: return BLK1_BASE[FLASH_AW-1:0];
            RGN_BLK2: return BLK2_BASE[FLASH_AW-1:0];
            RGN_BLK3: return BLK3_BASE[FLASH_AW-1:0];
            default:  return FLASH_BASE[FLASH_AW-1:0];
        endcase
    endfunction

    function automatic logic [FLASH_AW-1:0] region_last(input logic [2:0] r);
        case (r)
            RGN_BLK0: return BLK0_LAST[FLASH_AW-1:0];
            RGN_BLK1: return BLK1_LAST[FLASH_AW-1:0];
            RGN_BLK2: return BLK2_LAST[FLASH_AW-1:0];
            RGN_BLK3: return FLASH_LAST[FLASH_AW-1:0];
            default:  return BOOT_LAST[FLASH_AW-1:0];
        endcase
    endfunction

    function automatic logic is_id(input logic [21:0] a);
        return (a >= ID_BASE) && (a <= ID_LAST);
    endfunction

    function automatic logic is_cfg(input logic [21:0] a);
        return (a >= CFG_DEBUG) && (a <= CFG_RD_HI);
    endfunction
endpackage

// >>> hw/fcp_protect.sv
// Access protection for program flash, data EEPROM and config bytes; ID bytes stay open to both sides
`timescale 1ns/1ns
module fcp_protect
    import fcp_pkg::*;
#(
    parameter logic [15:0] DEVICE_ID_VAL = 16'h1234  // Arbitrary value
)(
    // Clock and reset
    input  wire logic         mclk_in,
    input  wire logic         rst_n_in,
    // CPU table access
    input  wire fcp_cpu_req_t cpu_req_in,
    output fcp_resp_t         cpu_resp_out,
    // External programmer
    input  wire logic         pgm_mode_in,
    input  wire fcp_pgm_req_t pgm_req_in,
    output fcp_resp_t         pgm_resp_out,
    output logic              pgm_busy_out,
    // Debugger
    output logic              debug_enable_out
);

    // Config byte readback
    function automatic logic [7:0] cfg_byte(input fcp_locks_t l, input logic [21:0] a);
        logic [7:0] b;
        b = BYTE_ZERO;
        case (a)
            CFG_DEBUG:  b = l.debug;
            CFG_EXT_LO: b[BLK_LK_MSB:0] = l.ext[NREG-1:1];
            CFG_EXT_HI: begin
                b[BIT_EE_ACC]  = l.ee_acc;
                b[BIT_BOOT_LK] = l.ext[RGN_BOOT];
            end
            CFG_WR_LO:  b[BLK_LK_MSB:0] = l.wr[NREG-1:1];
            CFG_WR_HI:  begin
                b[BIT_EE_WR]   = l.ee_wr;
                b[BIT_BOOT_LK] = l.wr[RGN_BOOT];
                b[BIT_CFG_WR]  = l.cfg_wr;
            end
            CFG_RD_LO:  b[BLK_LK_MSB:0] = l.rd[NREG-1:1];
            CFG_RD_HI:  b[BIT_BOOT_LK] = l.rd[RGN_BOOT];
            default:    b = BYTE_ZERO;
        endcase
        return b;
    endfunction

    // Config byte write; lock bits may only fall, the debug byte takes any value
    function automatic fcp_locks_t lock_write(input fcp_locks_t l, input logic [21:0] a,
                                              input logic [7:0] d, input logic ext);
        fcp_locks_t n;
        n = l;
        case (a)
            CFG_DEBUG:  n.debug = d;
            CFG_EXT_LO: n.ext[NREG-1:1] = l.ext[NREG-1:1] & d[BLK_LK_MSB:0];
            CFG_EXT_HI: begin
                n.ee_acc        = l.ee_acc & d[BIT_EE_ACC];
                n.ext[RGN_BOOT] = l.ext[RGN_BOOT] & d[BIT_BOOT_LK];
            end
            CFG_WR_LO:  n.wr[NREG-1:1] = l.wr[NREG-1:1] & d[BLK_LK_MSB:0];
            CFG_WR_HI:  begin
                n.ee_wr        = l.ee_wr & d[BIT_EE_WR];
                n.wr[RGN_BOOT] = l.wr[RGN_BOOT] & d[BIT_BOOT_LK];
                if (ext) begin
                    n.cfg_wr = l.cfg_wr & d[BIT_CFG_WR];
                end
            end
            CFG_RD_LO:  n.rd[NREG-1:1] = l.rd[NREG-1:1] & d[BLK_LK_MSB:0];
            CFG_RD_HI:  n.rd[RGN_BOOT] = l.rd[RGN_BOOT] & d[BIT_BOOT_LK];
            default:    n = l;
        endcase
        return n;
    endfunction

    function automatic logic [7:0] devid_byte(input logic [21:0] a);
        if (a == DEVID_LO) return DEVICE_ID_VAL[7:0];
        else if (a == DEVID_HI) return DEVICE_ID_VAL[15:8];
        else return BYTE_ZERO;
    endfunction

    // Storage
    logic [7:0]          flash_mem [0:(1<<FLASH_AW)-1];
    logic [7:0]          ee_mem    [0:(1<<EE_AW)-1];
    logic [7:0]          id_mem    [0:(1<<ID_AW)-1];
    fcp_locks_t          locks_reg;
    fcp_locks_t          locks_next;
    fcp_state_t          state_reg;
    fcp_state_t          state_next;
    logic [FLASH_AW-1:0] erase_ptr_reg;
    logic [FLASH_AW-1:0] erase_ptr_next;
    logic [FLASH_AW-1:0] erase_last_reg;
    logic [FLASH_AW-1:0] erase_last_next;
    logic                erase_chip_reg;
    logic                erase_chip_next;
    fcp_resp_t           cpu_resp_next;
    fcp_resp_t           pgm_resp_next;

    // CPU side decode
    wire logic                cpu_take     = cpu_req_in.valid & ~pgm_mode_in;
    wire logic                cpu_wr       = cpu_take & cpu_req_in.write;
    wire logic [2:0]          cpu_rgn      = region_of(cpu_req_in.addr);
    wire logic [2:0]          pc_rgn       = region_of(cpu_req_in.pc);
    wire logic                cpu_in_flash = (cpu_rgn != RGN_NONE);
    wire logic                cpu_is_id    = is_id(cpu_req_in.addr);
    wire logic                cpu_is_cfg   = is_cfg(cpu_req_in.addr);
    wire logic [FLASH_AW-1:0] cpu_fl_idx   = cpu_req_in.addr[FLASH_AW-1:0];
    wire logic [EE_AW-1:0]    cpu_ee_idx   = cpu_req_in.addr[EE_AW-1:0];
    wire logic [ID_AW-1:0]    cpu_id_idx   = cpu_req_in.addr[ID_AW-1:0];
    wire logic [7:0]          cpu_fl_byte  = flash_mem[cpu_fl_idx];
    wire logic [7:0]          cpu_ee_byte  = ee_mem[cpu_ee_idx];
    wire logic [7:0]          cpu_id_byte  = id_mem[cpu_id_idx];
    wire logic                cpu_rd_allow = locks_reg.rd[cpu_rgn] | (pc_rgn == cpu_rgn);
    wire logic [7:0]          cpu_rd_byte  = cpu_req_in.ee ? cpu_ee_byte
                                           : cpu_in_flash ? (cpu_rd_allow ? cpu_fl_byte : BYTE_ZERO)
                                           : cpu_is_id ? cpu_id_byte
                                           : cpu_is_cfg ? cfg_byte(locks_reg, cpu_req_in.addr)
                                           : devid_byte(cpu_req_in.addr);
    wire logic cpu_ee_wr_en  = cpu_wr & cpu_req_in.ee;
    wire logic cpu_fl_wr_en  = cpu_wr & ~cpu_req_in.ee & cpu_in_flash
                             & locks_reg.wr[cpu_rgn];
    wire logic cpu_id_wr_en  = cpu_wr & ~cpu_req_in.ee & cpu_is_id;
    wire logic cpu_cfg_wr_en = cpu_wr & ~cpu_req_in.ee & cpu_is_cfg & locks_reg.cfg_wr;

    // Programmer side decode
    wire logic                pgm_take     = pgm_req_in.valid & pgm_mode_in & (state_reg == ST_IDLE);
    wire logic                pgm_wr       = pgm_take & (pgm_req_in.op == OP_WRITE);
    wire logic                pgm_rd       = pgm_take & (pgm_req_in.op == OP_READ);
    wire logic [2:0]          pgm_rgn      = region_of(pgm_req_in.addr);
    wire logic                pgm_in_flash = (pgm_rgn != RGN_NONE);
    wire logic                pgm_is_id    = is_id(pgm_req_in.addr);
    wire logic                pgm_is_cfg   = is_cfg(pgm_req_in.addr);
    wire logic [FLASH_AW-1:0] pgm_fl_idx   = pgm_req_in.addr[FLASH_AW-1:0];
    wire logic [EE_AW-1:0]    pgm_ee_idx   = pgm_req_in.addr[EE_AW-1:0];
    wire logic [ID_AW-1:0]    pgm_id_idx   = pgm_req_in.addr[ID_AW-1:0];
    wire logic [7:0]          pgm_ee_byte  = ee_mem[pgm_ee_idx];
    wire logic                pgm_fl_open  = pgm_in_flash & locks_reg.ext[pgm_rgn];
    wire logic [7:0]          pgm_rd_byte  = pgm_req_in.ee ? (locks_reg.ee_acc ? pgm_ee_byte : BYTE_ZERO)
                                           : pgm_in_flash ? (pgm_fl_open ? flash_mem[pgm_fl_idx] : BYTE_ZERO)
                                           : pgm_is_id ? id_mem[pgm_id_idx]
                                           : pgm_is_cfg ? cfg_byte(locks_reg, pgm_req_in.addr)
                                           : devid_byte(pgm_req_in.addr);
    wire logic pgm_ee_wr_en  = pgm_wr & pgm_req_in.ee & locks_reg.ee_acc & locks_reg.ee_wr;
    wire logic pgm_fl_wr_en  = pgm_wr & ~pgm_req_in.ee & pgm_fl_open;
    wire logic pgm_id_wr_en  = pgm_wr & ~pgm_req_in.ee & pgm_is_id;
    wire logic pgm_cfg_wr_en = pgm_wr & ~pgm_req_in.ee & pgm_is_cfg & locks_reg.cfg_wr;
    wire logic chip_erase    = pgm_take & (pgm_req_in.op == OP_CHIP_ERASE);
    wire logic blk_erase     = pgm_take & (pgm_req_in.op == OP_BLOCK_ERASE) & pgm_in_flash;
    wire logic erase_start   = chip_erase | blk_erase;
    wire logic erasing       = (state_reg == ST_ERASE);
    wire logic erase_done    = erasing & (erase_ptr_reg == erase_last_reg);
    wire logic ee_sweep      = erasing & erase_chip_reg & (erase_ptr_reg < EE_SWEEP_END);

    wire logic [PROT_W-1:0] prot_vec = {locks_reg.ext, locks_reg.wr, locks_reg.rd,
                                        locks_reg.ee_acc, locks_reg.ee_wr, locks_reg.cfg_wr};

    // Lock bit update
    always_comb begin
        locks_next = locks_reg;
        if (cpu_cfg_wr_en) begin
            locks_next = lock_write(locks_reg, cpu_req_in.addr, cpu_req_in.wdata, 1'b0);
        end
        if (pgm_cfg_wr_en) begin
            locks_next = lock_write(locks_reg, pgm_req_in.addr, pgm_req_in.wdata, 1'b1);
        end
        if (chip_erase) begin
            locks_next.ext    = LOCKS_ERASED;
            locks_next.wr     = LOCKS_ERASED;
            locks_next.rd     = LOCKS_ERASED;
            locks_next.ee_acc = 1'b1;
            locks_next.ee_wr  = 1'b1;
            locks_next.cfg_wr = 1'b1;
        end
        if (blk_erase) begin
            locks_next.ext[pgm_rgn] = 1'b1;
            locks_next.wr[pgm_rgn]  = 1'b1;
            locks_next.rd[pgm_rgn]  = 1'b1;
        end
    end

    // Erase sweep sequencer
    always_comb begin
        state_next      = state_reg;
        erase_ptr_next  = erase_ptr_reg;
        erase_last_next = erase_last_reg;
        erase_chip_next = erase_chip_reg;
        case (state_reg)
            ST_IDLE: begin
                if (erase_start) begin
                    state_next      = ST_ERASE;
                    erase_chip_next = chip_erase;
                    erase_ptr_next  = chip_erase ? FLASH_BASE[FLASH_AW-1:0] : region_base(pgm_rgn);
                    erase_last_next = chip_erase ? FLASH_LAST[FLASH_AW-1:0] : region_last(pgm_rgn);
                end
            end
            ST_ERASE: begin
                erase_ptr_next = erase_ptr_reg + 1'b1;
                if (erase_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Answers
    always_comb begin
        cpu_resp_next.done  = cpu_take;
        cpu_resp_next.rdata = (cpu_take & ~cpu_req_in.write) ? cpu_rd_byte : cpu_resp_out.rdata;
        pgm_resp_next.done  = (pgm_take & ~erase_start) | erase_done;
        pgm_resp_next.rdata = pgm_rd ? pgm_rd_byte : pgm_resp_out.rdata;
    end

    // Memory arrays
    always_ff @(posedge mclk_in) begin
        if (cpu_ee_wr_en) ee_mem[cpu_ee_idx] <= cpu_req_in.wdata;
        if (pgm_ee_wr_en) ee_mem[pgm_ee_idx] <= pgm_req_in.wdata;
        if (ee_sweep) ee_mem[erase_ptr_reg[EE_AW-1:0]] <= BYTE_ERASED;
        if (cpu_fl_wr_en) flash_mem[cpu_fl_idx] <= cpu_req_in.wdata;
        if (pgm_fl_wr_en) flash_mem[pgm_fl_idx] <= pgm_req_in.wdata;
        if (erasing) flash_mem[erase_ptr_reg] <= BYTE_ERASED;
        if (cpu_id_wr_en) id_mem[cpu_id_idx] <= cpu_req_in.wdata;
        if (pgm_id_wr_en) id_mem[pgm_id_idx] <= pgm_req_in.wdata;
    end

    // Control state and outputs
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            locks_reg        <= LOCKS_RESET;
            state_reg        <= ST_IDLE;
            erase_ptr_reg    <= '0;
            erase_last_reg   <= '0;
            erase_chip_reg   <= 1'b0;
            cpu_resp_out     <= '0;
            pgm_resp_out     <= '0;
            pgm_busy_out     <= 1'b0;
            debug_enable_out <= 1'b0;
        end else begin
            locks_reg        <= locks_next;
            state_reg        <= state_next;
            erase_ptr_reg    <= erase_ptr_next;
            erase_last_reg   <= erase_last_next;
            erase_chip_reg   <= erase_chip_next;
            cpu_resp_out     <= cpu_resp_next;
            pgm_resp_out     <= pgm_resp_next;
            pgm_busy_out     <= (state_next == ST_ERASE);
            debug_enable_out <= ~locks_next.debug[BIT_DEBUG];
        end
    end

    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    a_cross_read_zero: assert property (
        cpu_take & ~cpu_req_in.write & ~cpu_req_in.ee & cpu_in_flash & ~cpu_rd_allow
        |=> cpu_resp_out.done && (cpu_resp_out.rdata == BYTE_ZERO))
        else $error("Cross-region read not zeroed");

    a_own_read_true: assert property (
        cpu_take & ~cpu_req_in.write & ~cpu_req_in.ee & cpu_in_flash & (pc_rgn == cpu_rgn)
        |=> cpu_resp_out.rdata == $past(cpu_fl_byte))
        else $error("Same-region read altered");

    a_write_lock_hold: assert property (
        cpu_wr & ~cpu_req_in.ee & cpu_in_flash & ~locks_reg.wr[cpu_rgn] & ~erasing
        |=> flash_mem[$past(cpu_fl_idx)] == $past(cpu_fl_byte))
        else $error("Locked region was written");

    a_refused_silent: assert property (
        cpu_wr & cpu_in_flash & ~locks_reg.wr[cpu_rgn]
        |=> cpu_resp_out.done && $stable(prot_vec))
        else $error("Refused write not silent");

    a_clear_only: assert property (
        !erase_start |=> (prot_vec & ~$past(prot_vec)) == '0)
        else $error("Lock bit rose without erase");

    a_erase_source: assert property (
        $rose(erasing) |-> $past(pgm_mode_in) && $past(pgm_req_in.valid))
        else $error("Erase not from programmer");

    a_ee_read_block: assert property (
        pgm_rd & pgm_req_in.ee & ~locks_reg.ee_acc |=> pgm_resp_out.rdata == BYTE_ZERO)
        else $error("EEPROM read not blocked");

    a_ee_write_block: assert property (
        pgm_wr & pgm_req_in.ee & ~locks_reg.ee_wr |=> ee_mem[$past(pgm_ee_idx)] == $past(pgm_ee_byte))
        else $error("EEPROM write not blocked");

    a_cpu_ee_free: assert property (
        cpu_take & ~cpu_req_in.write & cpu_req_in.ee |=> cpu_resp_out.rdata == $past(cpu_ee_byte))
        else $error("CPU EEPROM read blocked");

    a_cfg_lock_hold: assert property (
        ~locks_reg.cfg_wr & ~erase_start |=> $stable(locks_reg))
        else $error("Config changed while locked");

    a_cfg_lock_cpu: assert property (
        !pgm_take |=> $stable(locks_reg.cfg_wr))
        else $error("Config lock changed by CPU");

    a_id_readable: assert property (
        cpu_take & ~cpu_req_in.write & ~cpu_req_in.ee & cpu_is_id
        |=> cpu_resp_out.rdata == $past(cpu_id_byte))
        else $error("ID byte not readable");

    a_debug_follow: assert property (
        debug_enable_out == ~locks_reg.debug[BIT_DEBUG])
        else $error("Debug enable mismatch");

    a_blk_erase_sets: assert property (
        blk_erase
        |=> locks_reg.ext[$past(pgm_rgn)] & locks_reg.wr[$past(pgm_rgn)] & locks_reg.rd[$past(pgm_rgn)])
        else $error("Block erase left locks low");

    a_chip_erase_sets: assert property (
        chip_erase |=> &prot_vec)
        else $error("Chip erase left locks low");

    a_ee_read_open: assert property (
        pgm_rd & pgm_req_in.ee & locks_reg.ee_acc
        |=> pgm_resp_out.rdata == $past(pgm_ee_byte))
        else $error("EEPROM read wrongly blocked");

    a_id_write: assert property (
        cpu_id_wr_en
        |=> id_mem[$past(cpu_id_idx)] == $past(cpu_req_in.wdata))
        else $error("ID byte write lost");

    a_ext_read_zero: assert property (
        pgm_rd & ~pgm_req_in.ee & pgm_in_flash & ~locks_reg.ext[pgm_rgn]
        |=> pgm_resp_out.rdata == BYTE_ZERO)
        else $error("Protected flash read not zeroed");

    a_pgm_answer: assert property (
        pgm_take & ~erase_start |=> pgm_resp_out.done)
        else $error("Programmer request not answered");

    c_cross_zero: cover property (cpu_take & ~cpu_req_in.write & cpu_in_flash & ~cpu_rd_allow);
    c_block_erase: cover property (blk_erase ##1 erasing [*3]);
    c_pgm_flash_read: cover property (pgm_rd & pgm_fl_open);
    c_cpu_ee_write: cover property (cpu_ee_wr_en);
    c_chip_erase: cover property (chip_erase);

endmodule

// >>> testbench/fcp_pgm_model.sv
// Programmer-side model driving the decoded serial programming link
`timescale 1ns/1ns
module fcp_pgm_model
    import fcp_pkg::*;
(
    // Clock
    input  wire logic      mclk_in,
    // Link to block
    input  wire fcp_resp_t pgm_resp_in,
    output logic           pgm_mode_out,
    output fcp_pgm_req_t   pgm_req_out
);
    initial begin
        pgm_mode_out = 1'b0;
        pgm_req_out = '0;
    end
    // One transfer; erase only ever starts here
    task automatic xfer(input fcp_op_t op, input logic ee, input logic [21:0] a,
                        input logic [7:0] d, output logic [7:0] rd, output logic ok);
        int n;
        n = 0;
        if (a inside {CFG_EXT_LO, CFG_WR_LO, CFG_RD_LO}) d[3:2] = 2'b11;
        @(posedge mclk_in);
        #1;
        pgm_mode_out = 1'b1;
        pgm_req_out = '{valid: 1'b1, op: op, ee: ee, addr: a, wdata: d};
        @(posedge mclk_in);
        #1;
        pgm_req_out = '{valid: 1'b0, op: op, ee: ee, addr: ~a, wdata: ~d};
        while (pgm_resp_in.done !== 1'b1 && n < 20000) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        ok = (pgm_resp_in.done === 1'b1);
        rd = pgm_resp_in.rdata;
        pgm_mode_out = 1'b0;
    endtask
endmodule

// >>> testbench/fcp_protect_test.sv
// Self-checking bench for the flash code protection block
`timescale 1ns/1ns
module fcp_protect_test
    import fcp_pkg::*;
;
    localparam logic [15:0] ID_VAL = 16'h5a3c; // Arbitrary value
    logic mclk_in, rst_n_in, pgm_mode_in, pgm_busy_out, debug_enable_out, ok;
    logic [7:0] rd;
    fcp_cpu_req_t cpu_req_in;
    fcp_pgm_req_t pgm_req_in;
    fcp_resp_t cpu_resp_out, pgm_resp_out;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    int busy_cnt = 0;
    fcp_protect #(.DEVICE_ID_VAL(ID_VAL)) fcp_protect_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .cpu_req_in(cpu_req_in), .cpu_resp_out(cpu_resp_out), .pgm_mode_in(pgm_mode_in),
        .pgm_req_in(pgm_req_in), .pgm_resp_out(pgm_resp_out), .pgm_busy_out(pgm_busy_out),
        .debug_enable_out(debug_enable_out));
    fcp_pgm_model fcp_pgm_model_i (.mclk_in(mclk_in), .pgm_resp_in(pgm_resp_out),
        .pgm_mode_out(pgm_mode_in), .pgm_req_out(pgm_req_in));
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            $display("ERROR %0t timeout", $time);
            results();
        end
    end
    always @(negedge mclk_in) begin
        if (pgm_busy_out === 1'b1) busy_cnt++;
    end
    task automatic results;
        $display("Counts: checks %0d, errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Busy cycles of the last sweep; busy must be low again
    task automatic chk_busy(input int exp);
        checks++;
        if (busy_cnt != exp || pgm_busy_out !== 1'b0) begin
            err_total++;
            $display("ERROR %0t busy for %0d cycles, expected %0d", $time, busy_cnt, exp);
        end
        busy_cnt = 0;
    endtask
    // Table op; d is write data, or expected data on a read
    task automatic cpu(input logic w, input logic ee, input logic [21:0] a, input logic [21:0] pc,
                       input logic [7:0] d);
        @(posedge mclk_in);
        #1;
        cpu_req_in = '{valid: 1'b1, write: w, ee: ee, addr: a, pc: pc, wdata: d};
        @(posedge mclk_in);
        #1;
        cpu_req_in = '{valid: 1'b0, write: w, ee: ee, addr: ~a, pc: ~pc, wdata: ~d};
        chk({7'h0, cpu_resp_out.done}, 8'h01);
        if (!w) chk(cpu_resp_out.rdata, d);
    endtask
    task automatic pgm(input fcp_op_t op, input logic ee, input logic [21:0] a, input logic [7:0] d);
        fcp_pgm_model_i.xfer(op, ee, a, d, rd, ok);
        chk({7'h0, ok}, 8'h01);
        if (op == OP_READ) chk(rd, d);
    endtask
    task automatic t_access;
        pgm(OP_WRITE, 0, 22'h000300, 8'h5a);
        pgm(OP_WRITE, 0, CFG_DEBUG, 8'h7f);
        cpu(0, 0, DEVID_LO, 22'h0, ID_VAL[7:0]);
        cpu(1, 0, ID_BASE, 22'h0, 8'h77);
        cpu(0, 0, ID_BASE, 22'h0, 8'h77);
    endtask
    task automatic t_locks;
        pgm(OP_WRITE, 0, CFG_WR_LO, 8'hfe);
        cpu(1, 0, 22'h000300, 22'h0, 8'h11);
        cpu(0, 0, 22'h000300, 22'h000300, 8'h5a);
        cpu(1, 0, BLK1_BASE, 22'h0, 8'h22);
        pgm(OP_WRITE, 0, CFG_WR_LO, 8'hff);
        pgm(OP_READ, 0, CFG_WR_LO, 8'h0e);
        pgm(OP_WRITE, 0, CFG_RD_LO, 8'hfe);
        cpu(0, 0, 22'h000300, BLK0_LAST, 8'h5a);
        cpu(0, 0, 22'h000300, BOOT_LAST, 8'h00);
        cpu(0, 0, 22'h000300, BLK1_BASE, 8'h00);
        cpu(0, 0, BLK1_BASE, 22'h000300, 8'h22);
        pgm(OP_WRITE, 0, CFG_EXT_LO, 8'hfe);
        pgm(OP_READ, 0, 22'h000300, 8'h00);
        cpu(0, 0, 22'h000300, BLK0_BASE, 8'h5a);
        cpu(0, 0, ID_BASE, 22'h000300, 8'h77);
    endtask
    task automatic t_eeprom;
        pgm(OP_WRITE, 1, 22'h10, 8'h99);
        pgm(OP_WRITE, 0, CFG_WR_HI, 8'h7f);
        pgm(OP_WRITE, 1, 22'h10, 8'h00);
        pgm(OP_READ, 1, 22'h10, 8'h99);
        cpu(1, 1, 22'h10, 22'h0, 8'h44);
        pgm(OP_WRITE, 0, CFG_EXT_HI, 8'h7f);
        pgm(OP_READ, 1, 22'h10, 8'h00);
        cpu(0, 1, 22'h10, 22'h0, 8'h44);
    endtask
    task automatic t_config;
        cpu(1, 0, CFG_WR_HI, 22'h0, 8'h00);
        pgm(OP_READ, 0, CFG_WR_HI, 8'h20);
        pgm(OP_WRITE, 0, CFG_WR_HI, 8'h00);
        pgm(OP_WRITE, 0, CFG_RD_LO, 8'h00);
        cpu(1, 0, CFG_RD_LO, 22'h0, 8'h00);
        pgm(OP_READ, 0, CFG_RD_LO, 8'h0e);
    endtask
    task automatic t_erase;
        pgm(OP_BLOCK_ERASE, 0, 22'h000300, 8'h00);
        chk_busy(int'(BLK0_LAST - BLK0_BASE) + 1);
        pgm(OP_READ, 0, CFG_WR_LO, 8'h0f);
        pgm(OP_READ, 0, 22'h000300, 8'hff);
        pgm(OP_CHIP_ERASE, 0, 22'h0, 8'h00);
        chk_busy(int'(FLASH_LAST - FLASH_BASE) + 1);
        pgm(OP_READ, 0, CFG_WR_HI, 8'he0);
        pgm(OP_READ, 0, CFG_EXT_HI, 8'hc0);
        chk({7'h0, debug_enable_out}, 8'h01);
    endtask
    initial begin
        rst_n_in = 1'b0;
        cpu_req_in = '0;
        repeat (4) @(posedge mclk_in);
        #1;
        rst_n_in = 1'b1;
        t_access();
        t_locks();
        t_eeprom();
        t_config();
        t_erase();
        results();
    end
endmodule
